/* File: logic/config_space_bar_and_cis_regs.sv */
// Config header slice: extension window base address and card info regs
module config_space_bar_and_cis_regs
  import cfg_window_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        cfg_write_in,
  input  wire logic        cfg_read_in,
  input  wire logic [7:0]  cfg_offset_in,
  input  wire logic [3:0]  cfg_byte_enable_in,
  input  wire logic [31:0] cfg_write_data_in,
  output logic      [31:0] cfg_read_data_out,
  output logic             cfg_read_valid_out,
  output logic      [17:0] extension_window_pointer_out
);

  // Base address register at 14h, bit by bit:
  //   31..14  window pointer, writable, resets to zero
  //   13..4   window size, fixed zero: a 16K-byte window
  //   3       prefetch, fixed zero: not prefetchable
  //   2..1    memory type, fixed 00: 32-bit, anywhere below 4G
  //   0       space indicator, fixed zero: memory space
  // Sizing software writes all ones and reads the fixed zeros back to
  // learn the window size, so those bits must never store write data.
  //
  // Card info base at 18h and pointer at 28h read zero in full, since
  // the card-bus strap is held high. Other dwords read zero as well.
  //
  // Byte lanes against the base register:
  //   lane 3  bits 31..24, all pointer
  //   lane 2  bits 23..16, all pointer
  //   lane 1  bits 15..8, pointer only in 15..14
  //   lane 0  bits 7..0, fixed fields only
  //
  // Access timing:
  //   a strobe is taken on the rising edge that sees it high
  //   read data and its valid flag appear from that same edge
  //   read data then holds until the next read is taken
  //   a read and a write on one edge return the old value
  //   the pointer port follows a write from the edge that takes it
  //   reads and writes may come back to back
  //
  // Reset is synchronous: the pointer, the read data, the valid flag and
  // the pointer port all clear on an edge that sees reset high.
  //
  // Writes never fail. Bytes that land on fixed fields, and writes to
  // the card info words or to any other dword, are dropped silently.
  //
  // Limitation: the block does not check that the offset's low two bits
  // agree with the byte enables; the enables alone pick the bytes.

  // Stored state: only the pointer bits hold anything
  logic        [17:0] extension_window_pointer;
  logic        [17:0] next_extension_window_pointer;

  // Read path
  logic        [31:0] base_read_word;
  logic        [31:0] cis_base_read_word;
  logic        [31:0] card_info_structure_pointer_read_word;
  logic        [31:0] selected_word;
  logic        [31:0] next_read_data;
  logic               next_read_valid;

  // Write path
  logic        [31:0] merged_word;
  logic        [17:0] written_pointer;
  logic               pointer_update;

  // Address decode
  wire logic   [5:0]  access_dword;
  wire logic          hit_ext_base;
  wire logic          hit_cis_base;
  wire logic          hit_card_info_structure_pointer;
  wire logic          hit_none;
  wire logic          write_ext_base;
  wire logic          read_taken;

  // Fixed fields of the base address register
  wire logic   [9:0]  extension_window_size;
  wire logic          extension_window_prefetch;
  wire logic   [1:0]  extension_window_memory_type;
  wire logic          extension_window_space_indicator;

  // Byte lanes that carry pointer bits, and their write strobes
  wire logic   [3:0]  lane_holds_pointer;
  wire logic   [3:0]  lane_write;

  // Dword index of a config byte offset; the low two bits are dropped
  function automatic logic [5:0] dword_of(input logic [7:0] offset);
    dword_of = offset[7:2];
  endfunction : dword_of

  // A register is hit when the access lands anywhere in its dword
  function automatic logic offset_hit(input logic [5:0] dword,
                                      input logic [7:0] reg_offset);
    offset_hit = (dword == dword_of(reg_offset));
  endfunction : offset_hit

  // True when a byte lane overlaps the writable pointer bits
  function automatic logic lane_has_pointer(input int lane_idx);
    lane_has_pointer = ((lane_idx * 8) + 7) >= POINTER_LSB;
  endfunction : lane_has_pointer

  // The pointer is the upper part of a 32-bit base address word
  function automatic logic [17:0] pointer_field(input logic [31:0] word);
    pointer_field = word[31:POINTER_LSB];
  endfunction : pointer_field

  // Decode on the dword alone
  assign access_dword    = dword_of(cfg_offset_in);
  assign hit_ext_base    = offset_hit(access_dword, EXT_BASE_OFFSET);
  assign hit_cis_base    = offset_hit(access_dword, CIS_BASE_OFFSET);
  assign hit_card_info_structure_pointer = offset_hit(access_dword, CARD_INFO_STRUCTURE_POINTER_OFFSET);
  assign hit_none        = ~(hit_ext_base | hit_cis_base |
                             hit_card_info_structure_pointer);
  assign write_ext_base  = cfg_write_in & hit_ext_base;
  assign read_taken      = cfg_read_in;

  // Read-only fields are constants, so no write can ever reach them
  assign extension_window_size            = WINDOW_SIZE_VALUE;
  assign extension_window_prefetch        = PREFETCH_VALUE;
  assign extension_window_memory_type     = MEMORY_TYPE_VALUE;
  assign extension_window_space_indicator = SPACE_INDICATOR_VALUE;

  // The word that a read of 14h returns
  assign base_read_word = {extension_window_pointer,
                           extension_window_size,
                           extension_window_prefetch,
                           extension_window_memory_type,
                           extension_window_space_indicator};

  // The card-bus strap is tied high, so both card info words are zero
  assign cis_base_read_word    = CIS_READ_VALUE;
  assign card_info_structure_pointer_read_word = CIS_READ_VALUE;

  // Byte 0 holds only fixed fields, so a write to it alone stores nothing
  // Lane 1 carries two pointer bits; its other six bits are fixed
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign lane_holds_pointer[lane] = lane_has_pointer(lane);
      assign lane_write[lane]         = write_ext_base &
                                        cfg_byte_enable_in[lane] &
                                        lane_holds_pointer[lane];
    end
  endgenerate

  // Unselected bytes keep what the register reads back now
  byte_lane_merge u_merge (
    .old_in     (base_read_word),
    .wdata_in   (cfg_write_data_in),
    .be_in      (cfg_byte_enable_in),
    .merged_out (merged_word)
  );

  // Writes elsewhere, or to byte 0 alone, leave the pointer untouched
  assign written_pointer = pointer_field(merged_word);
  assign pointer_update  = |lane_write;

  // A write takes effect on the edge that sees it
  assign next_extension_window_pointer =
    pointer_update ? written_pointer
                   : extension_window_pointer;

  // One-hot and-or select; unmapped dwords fall through to zero
  assign selected_word =
    ({32{hit_ext_base}}    & base_read_word)        |
    ({32{hit_cis_base}}    & cis_base_read_word)    |
    ({32{hit_card_info_structure_pointer}} & card_info_structure_pointer_read_word) |
    ({32{hit_none}}        & UNMAPPED_READ_VALUE);

  // Read data holds between reads, so the last answer stays readable
  assign next_read_data  = read_taken ? selected_word : cfg_read_data_out;
  // Valid stands for exactly one cycle per read taken
  assign next_read_valid = read_taken;

  // Stored pointer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      extension_window_pointer <= POINTER_RESET;
    end else begin
      extension_window_pointer <= next_extension_window_pointer;
    end
  end

  // The port copy loads from the same next value, so it never lags
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      extension_window_pointer_out <= POINTER_RESET;
    end else begin
      extension_window_pointer_out <= next_extension_window_pointer;
    end
  end

  // Read data register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_read_data_out <= READ_RESET;
    end else begin
      cfg_read_data_out <= next_read_data;
    end
  end

  // Read valid flag
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_read_valid_out <= 1'b0;
    end else begin
      cfg_read_valid_out <= next_read_valid;
    end
  end
endmodule : config_space_bar_and_cis_regs

/* File: logic/cfg_window_pkg.sv */
// Constants for the extension window and card info structure config registers
package cfg_window_pkg;
  localparam logic [7:0]  EXT_BASE_OFFSET       = 8'h14;
  localparam logic [7:0]  CIS_BASE_OFFSET       = 8'h18;
  localparam logic [7:0]  CARD_INFO_STRUCTURE_POINTER_OFFSET    = 8'h28;
  localparam int          POINTER_LSB           = 14;
  localparam int          POINTER_WIDTH         = 18;
  localparam logic [17:0] POINTER_RESET         = 18'h00000;
  localparam logic [9:0]  WINDOW_SIZE_VALUE     = 10'h000;
  localparam logic        PREFETCH_VALUE        = 1'h0;
  localparam logic [1:0]  MEMORY_TYPE_VALUE     = 2'h0;
  localparam logic        SPACE_INDICATOR_VALUE = 1'h0;
  localparam logic [31:0] CIS_READ_VALUE        = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ_VALUE   = 32'h00000000;
  localparam logic [31:0] READ_RESET            = 32'h00000000;
endpackage : cfg_window_pkg

/* File: logic/byte_lane_merge.sv */
// Byte-enable merge of write data into a stored word
module byte_lane_merge (
  input  wire logic [31:0] old_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  be_in,
  output logic      [31:0] merged_out
);
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign merged_out[g*8 +: 8] = be_in[g] ? wdata_in[g*8 +: 8]
                                             : old_in[g*8 +: 8];
    end
  endgenerate
endmodule : byte_lane_merge

/* File: test/cfg_window_monitor.sv */
// Checker for the config register slice
module cfg_window_monitor import cfg_window_pkg::*;(input clk_in,rst_in,
  cfg_write_in,cfg_read_in,cfg_read_valid_out,input[7:0]cfg_offset_in,
  input[3:0]cfg_byte_enable_in,input[31:0]cfg_write_data_in,
  cfg_read_data_out,input[17:0]extension_window_pointer_out);
  wire e=cfg_offset_in[7:2]==EXT_BASE_OFFSET[7:2],v=cfg_read_valid_out;
  wire[31:0]d=cfg_read_data_out;wire[17:0]p=extension_window_pointer_out;
  default clocking @(posedge clk_in);endclocking default disable iff(rst_in);
  property p_ptr;cfg_read_in&&!cfg_write_in&&e|=>v&&d[31:14]==p;endproperty
  a_ptr:assert property(p_ptr)else $error("pointer read");
  property p_wr;cfg_write_in&&e&&(&cfg_byte_enable_in)|=>
    p==$past(cfg_write_data_in[31:14]);endproperty
  a_wr:assert property(p_wr)else $error("pointer write");
  property p_low;v|->d[13:0]==0;endproperty
  a_low:assert property(p_low)else $error("low bits");
  property p_cis;cfg_read_in&&!e|=>v&&d==0;endproperty
  a_cis:assert property(p_cis)else $error("card info read");
  // A stray write elsewhere must never move the window
  property p_ro;cfg_write_in&&!e|=>$stable(p);endproperty
  a_ro:assert property(p_ro)else $error("read-only write");
  // Sizing: all ones written, a quiet cycle, then a read of the window
  sequence s_all_ones;
    cfg_write_in&&e&&(&cfg_byte_enable_in)&&(&cfg_write_data_in);
  endsequence
  sequence s_read_ext;cfg_read_in&&!cfg_write_in&&e;endsequence
  property p_size;
    s_all_ones##1 !cfg_write_in##1 s_read_ext|=>v&&d==32'hffffc000;
  endproperty
  a_size:assert property(p_size)else $error("sizing read");
endmodule:cfg_window_monitor
bind config_space_bar_and_cis_regs cfg_window_monitor u_mon(.*);

/* File: test/tb_config_space_bar_and_cis_regs.sv */
// Bench for the config register slice
module tb_config_space_bar_and_cis_regs;
  timeunit 1ns;timeprecision 1ns;
  logic clk_in=0,rst_in=1,cfg_write_in=0,cfg_read_in=0,cfg_read_valid_out;
  logic[7:0]cfg_offset_in=0;logic[3:0]cfg_byte_enable_in=0;
  logic[31:0]cfg_write_data_in=0,cfg_read_data_out;
  logic[17:0]extension_window_pointer_out;int n_mismatch,comparisons;
  // Byte 1 write clears only bits 15..14; the card info write must not stick
  logic[75:0]rows[3]='{{8'h14,4'hf,32'hffffffff,32'hffffc000},
    {8'h14,4'h2,32'h0,32'hffff0000},{8'h18,4'hf,32'hffffffff,32'h0}};
  `define CHK(a,b) begin comparisons++;if((a)!==(b))begin n_mismatch++;\
    $display("CHECK FAILED %0t read-back mismatch",$time);end end
  config_space_bar_and_cis_regs u_config_space_bar_and_cis_regs(.*);
  initial forever #5 clk_in=~clk_in;
  initial begin #5us;n_mismatch++;print_verdict;end
  task automatic op(logic w,r,logic[7:0]o,logic[3:0]b,logic[31:0]x);
    @(posedge clk_in);{cfg_write_in,cfg_read_in,cfg_offset_in}<={w,r,o};
    {cfg_byte_enable_in,cfg_write_data_in}<={b,x};
    @(posedge clk_in);{cfg_write_in,cfg_read_in}<=0;#1;endtask:op
  task automatic print_verdict;$display("%0d/%0d",n_mismatch,comparisons);
    if(n_mismatch==0&&comparisons>0)$display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;endtask:print_verdict
  initial begin repeat(20)@(posedge clk_in);rst_in<=0;
    foreach(rows[i])begin
      op(1,0,rows[i][75:68],rows[i][67:64],rows[i][63:32]);
      op(0,1,rows[i][75:68],0,0);
      `CHK(cfg_read_data_out,rows[i][31:0])
      `CHK(cfg_read_valid_out,1'b1)
      $display("row %0d done",i);
    end
    op(0,1,8'h28,0,0);
    `CHK(cfg_read_data_out,32'h0)
    op(1,0,8'h14,4'h1,32'h0);
    op(1,0,8'h20,4'hf,32'hffffffff);
    `CHK(extension_window_pointer_out,18'h3fffc)
    op(0,1,8'h20,0,0);
    `CHK(cfg_read_data_out,32'h0)
    $display("read-only writes done");
    @(posedge clk_in)rst_in<=1;@(posedge clk_in)rst_in<=0;
    op(0,1,8'h14,0,0);
    `CHK(cfg_read_data_out,32'h0)
    `CHK(extension_window_pointer_out,18'h0)
    $display("reset done");
    print_verdict;
  end
endmodule:tb_config_space_bar_and_cis_regs
